// ==== dv/tdc_testbench.sv ====
// Purpose: self-checking bench for the thermal dac code generator
// Assumes: ports driven 1 ns after the rising edge of clk_sys
// Notes:   expected codes come from a bench-side clamp model
`timescale 1ns/10ps
`default_nettype none
module testbench
	import tdc_pkg::*;
;
	// ==================================================
	// clock, stimulus and counters
	logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0;
	logic int_temp_done = 1'b0, ext_temp_done = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [9:0] int_temp = 10'h000, ext_temp = 10'h000;
	logic ref_internal, dac_a_thermal, dac_b_thermal;
	logic dac_a_update, dac_b_update;
	logic [3:0] gain_two;
	logic [7:0] dac_a_code, dac_b_code, oa, ob, ea, eb, g;
	int n_errors = 0, cmp_count = 0, cyc = 0;
	always #2 clk_sys = ~clk_sys;
	tdc_thermal_dac_code_generator #(.TEMP_W(10)) tdc_thermal_dac_code_generator_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.int_temp_done(int_temp_done), .int_temp(int_temp),
		.ext_temp_done(ext_temp_done), .ext_temp(ext_temp),
		.ref_internal(ref_internal), .gain_two(gain_two),
		.dac_a_thermal(dac_a_thermal), .dac_b_thermal(dac_b_thermal),
		.dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
		.dac_a_update(dac_a_update), .dac_b_update(dac_b_update));
	// hang guard: whole run is well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 5000) begin
			n_errors++;
			finish_test();
		end
	end
	// ==================================================
	// helpers
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	// floor of integer degrees minus offset, clamped into 0..255
	function automatic logic [7:0] f(logic [9:0] t, logic [7:0] o);
		int d;
		d = int'($signed(t[9:2])) - int'($signed(o));
		if (d < 0) return 8'h00;
		if (d > 255) return 8'hFF;
		return d[7:0];
	endfunction
	// idle edge first so the strobe is never re-raised in one step
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys); #1;
		reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
		@(posedge clk_sys); #1;
		reg_wr = 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk_sys); #1;
		reg_addr = a;
		@(posedge clk_sys); #1;
		chk("reg_rdata", e, reg_rdata);
	endtask
	task automatic setofs(logic [7:0] a, logic [7:0] b);
		oa = a; ob = b;
		wr(TDC_ADDR_INT_OFS, a);
		wr(TDC_ADDR_EXT_OFS, b);
	endtask
	// both sensors complete together; en says which dacs follow
	task automatic meas(logic [9:0] ta, logic [9:0] tb, logic [1:0] en);
		@(posedge clk_sys); #1;
		int_temp = ta; ext_temp = tb;
		int_temp_done = 1'b1; ext_temp_done = 1'b1;
		if (en[0]) ea = f(ta, oa);
		if (en[1]) eb = f(tb, ob);
		@(posedge clk_sys); #1;
		int_temp_done = 1'b0; ext_temp_done = 1'b0;
		chk("dac_a_code", ea, dac_a_code);
		chk("dac_b_code", eb, dac_b_code);
		chk("update", {6'h00, en}, {6'h00, dac_b_update, dac_a_update});
		@(posedge clk_sys); #1;
		chk("update_end", 8'h00, {6'h00, dac_b_update, dac_a_update});
	endtask
	// ==================================================
	// main sequence
	initial begin
		g = 8'($urandom(28));
		oa = TDC_RST_OFS; ob = TDC_RST_OFS; ea = 8'h00; eb = 8'h00;
		repeat (6) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		chk("ref_internal", 8'h00, {7'h00, ref_internal});
		chk("gain_two", 8'h00, {4'h0, gain_two});
		rd(TDC_ADDR_CTRL3, TDC_RST_CTRL3);
		rd(TDC_ADDR_DAC_CFG, TDC_RST_DAC_CFG);
		rd(TDC_ADDR_LOAD_CFG, TDC_RST_LOAD_CFG);
		rd(TDC_ADDR_INT_OFS, 8'hD8);
		rd(TDC_ADDR_EXT_OFS, 8'hD8);
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00);
		meas(10'h064, 10'h064, 2'b00);
		wr(TDC_ADDR_LOAD_CFG, 8'h10);
		chk("ref_internal", 8'h01, {7'h00, ref_internal});
		wr(TDC_ADDR_LOAD_CFG, 8'h00);
		chk("ref_internal", 8'h00, {7'h00, ref_internal});
		for (int i = 0; i < 4; i++) begin
			g = 8'($urandom) & 8'h0F;
			wr(TDC_ADDR_DAC_CFG, g);
			chk("gain_two", g, {4'h0, gain_two});
		end
		wr(TDC_ADDR_CTRL3, 8'h20);
		chk("thermal", 8'h01, {6'h00, dac_b_thermal, dac_a_thermal});
		meas(10'h064, 10'h067, 2'b01);
		// dac b alone: dac a must hold its last code
		wr(TDC_ADDR_CTRL3, 8'h40);
		chk("thermal", 8'h02, {6'h00, dac_b_thermal, dac_a_thermal});
		meas(10'h0C8, 10'h064, 2'b10);
		wr(TDC_ADDR_CTRL3, 8'h60);
		chk("thermal", 8'h03, {6'h00, dac_b_thermal, dac_a_thermal});
		setofs(8'h80, 8'h00);
		meas(10'h200, 10'h1FC, 2'b11);
		meas(10'h1FC, 10'h3FF, 2'b11);
		setofs(8'h0A, 8'hD8);
		meas(10'h027, 10'h1FF, 2'b11);
		// corners below the offset and inside one degree
		setofs(8'hD8, 8'h00);
		meas(10'h200, 10'h003, 2'b11);
		setofs(8'h00, 8'hD8);
		meas(10'h003, 10'h200, 2'b11);
		for (int i = 0; i < 24; i++) begin
			setofs(8'($urandom), 8'($urandom));
			meas(10'($urandom), 10'($urandom), 2'b11);
		end
		rd(TDC_ADDR_INT_OFS, oa);
		rd(TDC_ADDR_EXT_OFS, ob);
		finish_test();
	end
endmodule // testbench
`default_nettype wire

// ==== hdl/tdc_thermal_dac_code_generator.sv ====
// Purpose: registers and thermal code path behind a quad 8-bit dac
// Assumes: register port and sensor results synchronous to clk_sys
// Notes:   temperatures arrive as 10-bit two's complement, quarter degrees
`timescale 1ns/10ps
`default_nettype none

module tdc_thermal_dac_code_generator
	import tdc_pkg::*;
#(
	parameter int TEMP_W = 10
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              reg_wr,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output var  logic [7:0]        reg_rdata,
	input  wire logic              int_temp_done,
	input  wire logic [TEMP_W-1:0] int_temp,
	input  wire logic              ext_temp_done,
	input  wire logic [TEMP_W-1:0] ext_temp,
	output var  logic              ref_internal,
	output var  logic [3:0]        gain_two,
	output var  logic              dac_a_thermal,
	output var  logic              dac_b_thermal,
	output var  logic [7:0]        dac_a_code,
	output var  logic [7:0]        dac_b_code,
	output var  logic              dac_a_update,
	output var  logic              dac_b_update
);
	// ======================================================
	// elaboration checks
	if (TEMP_W != 8 + TDC_FRAC_BITS) begin : g_chk
		$error("TEMP_W must be 8 integer bits plus fraction bits");
	end

	typedef struct packed {
		logic [7:0] ctrl3;
		logic [7:0] dac_cfg;
		logic [7:0] load_cfg;
		logic [7:0] int_ofs;
		logic [7:0] ext_ofs;
		logic [7:0] rdata;
		logic [7:0] code_a;
		logic [7:0] code_b;
		logic       upd_a;
		logic       upd_b;
	} tdc_state_s;

	tdc_state_s st_reg;
	tdc_state_s st_next;

	// signed difference with clamp; 9-bit range needs 10-bit math
	function automatic logic [7:0] thermal_code(
		input logic [TEMP_W-1:0] temp,
		input logic [7:0]        ofs
	);
		logic signed [9:0] diff;
		diff = {{2{temp[TEMP_W-1]}}, temp[TEMP_W-1:TDC_FRAC_BITS]}
			- {{2{ofs[7]}}, ofs};
		if (diff < 10'sd0)
			thermal_code = TDC_CODE_ZERO;
		else if (diff > 10'sd255)
			thermal_code = TDC_CODE_MAX;
		else
			thermal_code = diff[7:0];
		return thermal_code;
	endfunction

	// independent model for the checks: whole-int math, no 10-bit wrap
	function automatic logic [7:0] thermal_ref(
		input logic [TEMP_W-1:0] temp,
		input logic [7:0]        ofs
	);
		int d;
		d = int'($signed(temp[TEMP_W-1:TDC_FRAC_BITS])) - int'($signed(ofs));
		if (d < 0)
			d = 0;
		if (d > 255)
			d = 255;
		return d[7:0];
	endfunction

	// ======================================================
	// register write, readback and thermal refresh
	always_comb begin
		st_next = st_reg;
		st_next.upd_a = 1'b0;
		st_next.upd_b = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				TDC_ADDR_CTRL3:    st_next.ctrl3 = reg_wdata;
				TDC_ADDR_DAC_CFG:  st_next.dac_cfg = reg_wdata;
				TDC_ADDR_LOAD_CFG: st_next.load_cfg = reg_wdata;
				TDC_ADDR_INT_OFS:  st_next.int_ofs = reg_wdata;
				TDC_ADDR_EXT_OFS:  st_next.ext_ofs = reg_wdata;
				default: ;
			endcase
		end
		// readback is registered so reg_rdata is a flop
		case (reg_addr)
			TDC_ADDR_CTRL3:    st_next.rdata = st_reg.ctrl3;
			TDC_ADDR_DAC_CFG:  st_next.rdata = st_reg.dac_cfg;
			TDC_ADDR_LOAD_CFG: st_next.rdata = st_reg.load_cfg;
			TDC_ADDR_INT_OFS:  st_next.rdata = st_reg.int_ofs;
			TDC_ADDR_EXT_OFS:  st_next.rdata = st_reg.ext_ofs;
			default:           st_next.rdata = 8'h00;
		endcase
		// offset used is the one stored now, not a same-cycle write
		if (st_reg.ctrl3[TDC_CTRL3_INT_EN] && int_temp_done) begin
			st_next.code_a = thermal_code(int_temp, st_reg.int_ofs);
			st_next.upd_a  = 1'b1;
		end
		if (st_reg.ctrl3[TDC_CTRL3_EXT_EN] && ext_temp_done) begin
			st_next.code_b = thermal_code(ext_temp, st_reg.ext_ofs);
			st_next.upd_b  = 1'b1;
		end
	end

	// ======================================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_reg.ctrl3    <= TDC_RST_CTRL3;
			st_reg.dac_cfg  <= TDC_RST_DAC_CFG;
			st_reg.load_cfg <= TDC_RST_LOAD_CFG;
			st_reg.int_ofs  <= TDC_RST_OFS;
			st_reg.ext_ofs  <= TDC_RST_OFS;
			st_reg.rdata    <= 8'h00;
			st_reg.code_a   <= TDC_CODE_ZERO;
			st_reg.code_b   <= TDC_CODE_ZERO;
			st_reg.upd_a    <= 1'b0;
			st_reg.upd_b    <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ======================================================
	// outputs, all straight from flops
	assign reg_rdata     = st_reg.rdata;
	assign ref_internal  = st_reg.load_cfg[TDC_LOAD_REF_SEL];
	assign gain_two      = st_reg.dac_cfg[3:0];
	assign dac_a_thermal = st_reg.ctrl3[TDC_CTRL3_INT_EN];
	assign dac_b_thermal = st_reg.ctrl3[TDC_CTRL3_EXT_EN];
	assign dac_a_code    = st_reg.code_a;
	assign dac_b_code    = st_reg.code_b;
	assign dac_a_update  = st_reg.upd_a;
	assign dac_b_update  = st_reg.upd_b;

	// ======================================================
	// checks
	sequence s_int_meas;
		st_reg.ctrl3[TDC_CTRL3_INT_EN] && int_temp_done;
	endsequence

	property p_refresh_a;
		@(posedge clk_sys) disable iff (!rst_n)
		s_int_meas |=> dac_a_update;
	endproperty
	a_refresh_a: assert property (p_refresh_a)
		else $error("dac a not refreshed");

	property p_refresh_b;
		@(posedge clk_sys) disable iff (!rst_n)
		(st_reg.ctrl3[TDC_CTRL3_EXT_EN] && ext_temp_done) |=> dac_b_update;
	endproperty
	a_refresh_b: assert property (p_refresh_b)
		else $error("dac b not refreshed");

	property p_no_spur_a;
		@(posedge clk_sys) disable iff (!rst_n)
		!dac_a_thermal |=> !dac_a_update;
	endproperty
	a_no_spur_a: assert property (p_no_spur_a)
		else $error("dac a spurious update");

	property p_code_a;
		@(posedge clk_sys) disable iff (!rst_n)
		s_int_meas |=> dac_a_code ==
			thermal_ref($past(int_temp), $past(st_reg.int_ofs));
	endproperty
	a_code_a: assert property (p_code_a)
		else $error("dac a code wrong");

	property p_hold_a;
		@(posedge clk_sys) disable iff (!rst_n)
		!dac_a_update |-> dac_a_code == $past(dac_a_code);
	endproperty
	a_hold_a: assert property (p_hold_a)
		else $error("dac a code moved");

	property p_sat;
		@(posedge clk_sys) disable iff (!rst_n)
		(s_int_meas and (int_temp == 10'h1FC) and (st_reg.int_ofs == 8'h80))
		|=> dac_a_code == TDC_CODE_MAX;
	endproperty
	a_sat: assert property (p_sat)
		else $error("no saturation");

	property p_clamp;
		@(posedge clk_sys) disable iff (!rst_n)
		(s_int_meas and (int_temp == 10'h200) and (st_reg.int_ofs == 8'hD8))
		|=> dac_a_code == TDC_CODE_ZERO;
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("no clamp at zero");

	property p_frac;
		@(posedge clk_sys) disable iff (!rst_n)
		(s_int_meas and (int_temp == 10'h003) and (st_reg.int_ofs == 8'h00))
		|=> dac_a_code == 8'h00;
	endproperty
	a_frac: assert property (p_frac)
		else $error("fraction not dropped");

	property p_gain;
		@(posedge clk_sys) disable iff (!rst_n)
		(reg_wr && reg_addr == TDC_ADDR_DAC_CFG) |=> gain_two == $past(reg_wdata[3:0]);
	endproperty
	a_gain: assert property (p_gain)
		else $error("gain bits not taken");

	property p_ref;
		@(posedge clk_sys)
		$rose(rst_n) |-> !ref_internal && st_reg.int_ofs == TDC_RST_OFS;
	endproperty
	a_ref: assert property (p_ref)
		else $error("reset defaults wrong");

endmodule : tdc_thermal_dac_code_generator
`default_nettype wire

// ==== inc/tdc_pkg.sv ====
// Purpose: constants for the thermal dac code generator
// Assumes: byte-wide register port, 8-bit dac codes
// Notes:   offsets are register addresses on the serial register port
`default_nettype none
package tdc_pkg;
	// ======================================================
	// register map
	localparam logic [7:0] TDC_ADDR_CTRL3     = 8'h1A;
	localparam logic [7:0] TDC_ADDR_DAC_CFG   = 8'h1B;
	localparam logic [7:0] TDC_ADDR_LOAD_CFG  = 8'h1C;
	localparam logic [7:0] TDC_ADDR_INT_OFS   = 8'h21;
	localparam logic [7:0] TDC_ADDR_EXT_OFS   = 8'h22;
	// ======================================================
	// field positions
	localparam int TDC_CTRL3_INT_EN  = 5;
	localparam int TDC_CTRL3_EXT_EN  = 6;
	localparam int TDC_LOAD_REF_SEL  = 4;
	localparam int TDC_DAC_A_DOUBLE  = 0;
	localparam int TDC_DAC_B_DOUBLE  = 1;
	// ======================================================
	// reset values, code limits and fraction width
	localparam logic [7:0] TDC_RST_CTRL3    = 8'h00;
	localparam logic [7:0] TDC_RST_DAC_CFG  = 8'h00;
	localparam logic [7:0] TDC_RST_LOAD_CFG = 8'h00;
	localparam logic [7:0] TDC_RST_OFS      = 8'hD8;
	localparam logic [7:0] TDC_CODE_MAX     = 8'hFF;
	localparam logic [7:0] TDC_CODE_ZERO    = 8'h00;
	localparam int TDC_FRAC_BITS = 2;
endpackage : tdc_pkg
`default_nettype wire
